// *** rt_mode_code_irq_queue_ctl.sv ***
// RT mode-command side effects, non-message interrupts and status queue writes.
// Assumes mode commands, end-of-message start and events come from logic on clk.
//
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module rt_mode_code_irq_queue_ctl
    import rmcq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rtMode,
    input wire logic modeCmdValid,
    input wire rmcq_pkg::rmcq_mode_cmd_t modeCmd,
    input wire logic eomStart,
    input wire logic timeTagTick,
    input wire logic terminalAddrParityIrq,
    input wire logic memParityIrq,
    output logic irq,
    output logic srqBit,
    output logic [15:0] timeTag,
    output rmcq_pkg::rmcq_queue_wr_t queueWr
);
    import rmcq_pkg::*;

    logic [15:0] cfg2_reg;
    logic [15:0] cfg6_reg;
    logic [15:0] imr1_reg;
    logic [15:0] isr1_reg;
    logic srq_reg;
    logic [15:0] timeTag_reg;
    logic pendSrq_reg;
    logic pendSync_reg;
    logic wrPend_reg;
    logic [7:0] wrAddr_reg;
    logic [31:0] hrdata_reg;
    rmcq_queue_wr_t queueWr_reg;

    // Bus decode; only whole-word single transfers, so hsize is not decoded
    wire logic addrAccept;
    wire logic rdAccept;
    wire logic [7:0] rdAddr;
    wire logic [15:0] wrData;
    wire logic wrCfg2;
    wire logic wrCfg6;
    wire logic wrImr1;
    wire logic wrSrq;
    wire logic readIsr;

    assign addrAccept = hsel && htrans[1] && hready;
    assign rdAccept = addrAccept && !hwrite;
    assign rdAddr = haddr[7:0];
    assign wrData = hwdata[15:0];
    assign wrCfg2 = wrPend_reg && (wrAddr_reg == CFG2_OFS);
    assign wrCfg6 = wrPend_reg && (wrAddr_reg == CFG6_OFS);
    assign wrImr1 = wrPend_reg && (wrAddr_reg == IMR1_OFS);
    assign wrSrq = wrPend_reg && (wrAddr_reg == SRQ_OFS);
    assign readIsr = rdAccept && (rdAddr == ISR1_OFS);

    // Configuration
    wire logic [15:0] cfg2Next;
    wire logic [15:0] cfg6Next;
    wire logic [15:0] imr1Next;
    wire logic srqClrEn;
    wire logic syncZeroEn;
    wire logic extMode;
    wire logic queueEn;

    assign cfg2Next = wrCfg2 ? wrData : cfg2_reg;
    assign cfg6Next = wrCfg6 ? wrData : cfg6_reg;
    assign imr1Next = wrImr1 ? wrData : imr1_reg;
    assign srqClrEn = cfg2_reg[SRQ_CLR_BIT];
    assign syncZeroEn = cfg2_reg[SYNC_ZERO_BIT];
    assign extMode = cfg2_reg[EXT_IRQ_BIT];
    assign queueEn = cfg6_reg[QUEUE_EN_BIT];

    // Mode commands are held pending until the message done sequence starts
    wire logic cmdSrq;
    wire logic cmdSync;
    wire logic srqClear;
    wire logic syncClear;
    wire logic pendSrqNext;
    wire logic pendSyncNext;

    assign cmdSrq = modeCmdValid && rtMode && modeCmd.txVector && srqClrEn;
    assign cmdSync = modeCmdValid && rtMode && modeCmd.syncNoData && syncZeroEn;
    // Clear path never looks at queue activity, so a late queue write cannot mask it
    assign srqClear = eomStart && pendSrq_reg;
    assign syncClear = eomStart && pendSync_reg;
    assign pendSrqNext = cmdSrq || (pendSrq_reg && !eomStart);
    assign pendSyncNext = cmdSync || (pendSync_reg && !eomStart);

    // Service request bit: software sets, the mode command clears with priority
    wire logic srqNext;
    assign srqNext = srqClear ? 1'h0 : (wrSrq ? wrData[0] : srq_reg);

    // Time tag counter
    wire logic ttWrap;
    wire logic [15:0] timeTagNext;
    assign ttWrap = timeTagTick && !syncClear && (timeTag_reg == TTAG_MAX);
    assign timeTagNext = syncClear ? TTAG_ZERO
        : (timeTagTick ? timeTag_reg + 16'h0001 : timeTag_reg);

    // Non-message interrupt events
    wire logic [15:0] nmiBits;
    wire logic [15:0] evtVec;
    wire logic [15:0] enabledEvt;
    wire logic [15:0] recMask;
    wire logic [15:0] isr1Next;
    wire logic queueFire;

    assign nmiBits = (16'(1'h1) << WRAP_BIT) | (16'(1'h1) << ADDR_PAR_BIT)
        | (16'(1'h1) << MEM_PAR_BIT);
    assign evtVec = (16'(ttWrap) << WRAP_BIT)
        | (16'(terminalAddrParityIrq) << ADDR_PAR_BIT)
        | (16'(memParityIrq) << MEM_PAR_BIT);
    assign enabledEvt = evtVec & imr1_reg & nmiBits;
    // Extended mode lets software poll events whose mask is off
    assign recMask = extMode ? ALL_ONES : imr1_reg;
    // A new event beats the read clear so it is never lost
    assign isr1Next = (isr1_reg & ~(readIsr ? ALL_ONES : NO_BITS))
        | (evtVec & recMask);
    assign queueFire = queueEn && (enabledEvt != NO_BITS);

    // Read data is taken from next values so a read right after a write sees it
    logic [31:0] rdNext;
    always_comb begin
        rdNext = RD_ZERO;
        if (!rdAccept) begin
            rdNext = hrdata_reg;
        end else if (rdAddr == CFG2_OFS) begin
            rdNext = {16'h0000, cfg2Next};
        end else if (rdAddr == CFG6_OFS) begin
            rdNext = {16'h0000, cfg6Next};
        end else if (rdAddr == IMR1_OFS) begin
            rdNext = {16'h0000, imr1Next};
        end else if (rdAddr == ISR1_OFS) begin
            rdNext = {16'h0000, isr1_reg | (evtVec & recMask)};
        end else if (rdAddr == SRQ_OFS) begin
            rdNext = {31'h0000_0000, srqNext};
        end else if (rdAddr == TTAG_OFS) begin
            rdNext = {16'h0000, timeTagNext};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPend_reg <= 1'h0;
            wrAddr_reg <= 8'h00;
            hrdata_reg <= RD_ZERO;
        end else begin
            wrPend_reg <= addrAccept && hwrite;
            wrAddr_reg <= addrAccept ? rdAddr : wrAddr_reg;
            hrdata_reg <= rdNext;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg2_reg <= CFG2_RST;
            cfg6_reg <= CFG6_RST;
            imr1_reg <= IMR1_RST;
            isr1_reg <= ISR1_RST;
        end else begin
            cfg2_reg <= cfg2Next;
            cfg6_reg <= cfg6Next;
            imr1_reg <= imr1Next;
            isr1_reg <= isr1Next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            srq_reg <= SRQ_RST;
            timeTag_reg <= TTAG_ZERO;
            pendSrq_reg <= 1'h0;
            pendSync_reg <= 1'h0;
        end else begin
            srq_reg <= srqNext;
            timeTag_reg <= timeTagNext;
            pendSrq_reg <= pendSrqNext;
            pendSync_reg <= pendSyncNext;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            queueWr_reg <= '0;
        end else begin
            queueWr_reg.valid <= queueFire;
            queueWr_reg.events <= enabledEvt;
            queueWr_reg.timeTag <= timeTag_reg;
        end
    end

    assign hreadyout = 1'h1;
    assign hresp = HRESP_OKAY;
    assign hrdata = hrdata_reg;
    assign irq = (isr1_reg & imr1_reg & nmiBits) != NO_BITS;
    assign srqBit = srq_reg;
    assign timeTag = timeTag_reg;
    assign queueWr = queueWr_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence srqCmdSeen;
        cmdSrq && !eomStart;
    endsequence

    sequence syncCmdSeen;
        cmdSync && !eomStart;
    endsequence

    // Queue entry lands one to five edges ahead of message done
    sequence lateQueueWrite;
        queueWr.valid ##[1:5] (eomStart && pendSrq_reg);
    endsequence

    sequence lateQueueSync;
        queueWr.valid ##[1:5] (eomStart && pendSync_reg);
    endsequence

    srq_clear_a: assert property (
        srqCmdSeen ##1 (eomStart [*1]) |=> !srqBit
    ) else $error("service request not cleared at message done");

    sync_zero_a: assert property (
        syncCmdSeen ##1 (eomStart && !timeTagTick) |=> timeTag == TTAG_ZERO
    ) else $error("time tag not zeroed after synchronize");

    irq_gate_a: assert property (
        (terminalAddrParityIrq && imr1_reg[ADDR_PAR_BIT] && !wrImr1) |=> irq
    ) else $error("unmasked address parity event gave no interrupt");

    irq_masked_a: assert property (
        (isr1_reg[MEM_PAR_BIT] && !imr1_reg[MEM_PAR_BIT]
            && !isr1_reg[WRAP_BIT] && !isr1_reg[ADDR_PAR_BIT]) |-> !irq
    ) else $error("masked event raised the interrupt");

    queue_off_a: assert property (
        !queueEn && !wrCfg6 |=> !queueWr.valid
    ) else $error("queue written while disabled");

    ext_mode_a: assert property (
        (wrCfg2 && wrData[EXT_IRQ_BIT]) |=> extMode
    ) else $error("extended mode bit not taken");

    wrap_poll_a: assert property (
        (extMode && ttWrap && !imr1_reg[WRAP_BIT]) |=> isr1_reg[WRAP_BIT]
    ) else $error("wrap not recorded in extended mode");

    queue_write_a: assert property (
        (queueEn && memParityIrq && imr1_reg[MEM_PAR_BIT])
            |=> queueWr.valid && queueWr.events[MEM_PAR_BIT]
    ) else $error("enabled event wrote no queue entry");

    clear_at_eom_a: assert property (
        (pendSync_reg && !eomStart && !timeTagTick && !syncClear)
            |=> timeTag == $past(timeTag)
    ) else $error("time tag cleared before message done");

    queue_race_a: assert property (
        lateQueueWrite |=> !srqBit
    ) else $error("queue write suppressed service request clear");

    queue_race_sync_a: assert property (
        lateQueueSync |=> timeTag == TTAG_ZERO
    ) else $error("queue write suppressed time tag clear");

    srq_hold_a: assert property (
        (pendSrq_reg && !eomStart && !wrSrq) |=> srqBit == $past(srqBit)
    ) else $error("service request cleared before message done");

    queue_addr_a: assert property (
        (queueEn && terminalAddrParityIrq && imr1_reg[ADDR_PAR_BIT])
            |=> queueWr.valid && queueWr.events[ADDR_PAR_BIT]
    ) else $error("address parity event wrote no queue entry");

    addr_rec_a: assert property (
        (terminalAddrParityIrq && !extMode && !imr1_reg[ADDR_PAR_BIT]
            && !isr1_reg[ADDR_PAR_BIT]) |=> !isr1_reg[ADDR_PAR_BIT]
    ) else $error("masked address parity event was recorded");

    sync_ignore_a: assert property (
        (modeCmdValid && !rtMode && !pendSync_reg && !eomStart) |=> !pendSync_reg
    ) else $error("synchronize taken outside terminal mode");

endmodule // rt_mode_code_irq_queue_ctl

// *** rmcq_pkg.sv ***
// Constants and carrier types for the RT mode-command and interrupt queue control block.
// Assumes a single 25 MHz clock domain and an AHB-Lite register bus.
package rmcq_pkg;

    // Register byte offsets
    localparam logic [7:0] CFG2_OFS = 8'h00;
    localparam logic [7:0] CFG6_OFS = 8'h04;
    localparam logic [7:0] IMR1_OFS = 8'h08;
    localparam logic [7:0] ISR1_OFS = 8'h0c;
    localparam logic [7:0] SRQ_OFS = 8'h10;
    localparam logic [7:0] TTAG_OFS = 8'h14;

    // Field positions
    localparam int SRQ_CLR_BIT = 2;
    localparam int SYNC_ZERO_BIT = 6;
    localparam int EXT_IRQ_BIT = 15;
    localparam int QUEUE_EN_BIT = 6;
    localparam int WRAP_BIT = 6;
    localparam int ADDR_PAR_BIT = 7;
    localparam int MEM_PAR_BIT = 14;

    // Values after reset and fixed values
    localparam logic [15:0] CFG2_RST = 16'h0000;
    localparam logic [15:0] CFG6_RST = 16'h0000;
    localparam logic [15:0] IMR1_RST = 16'h0000;
    localparam logic [15:0] ISR1_RST = 16'h0000;
    localparam logic SRQ_RST = 1'h0;
    localparam logic [15:0] TTAG_ZERO = 16'h0000;
    localparam logic [15:0] TTAG_MAX = 16'hffff;
    localparam logic [15:0] ALL_ONES = 16'hffff;
    localparam logic [15:0] NO_BITS = 16'h0000;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // AHB-Lite encodings
    localparam logic HRESP_OKAY = 1'h0;

    typedef struct packed {
        logic txVector;
        logic syncNoData;
    } rmcq_mode_cmd_t;

    typedef struct packed {
        logic valid;
        logic [15:0] events;
        logic [15:0] timeTag;
    } rmcq_queue_wr_t;

endpackage

// *** rmcq_bc_model.sv ***
// Bus controller model: issues mode commands, then starts the message done sequence.
// Assumes the caller enters its task just after a rising edge of clk.
`timescale 1ns/100ps
module rmcq_bc_model
    import rmcq_pkg::*;
(
    input wire logic clk,
    output logic modeCmdValid,
    output rmcq_pkg::rmcq_mode_cmd_t modeCmd,
    output logic eomStart
);
    initial begin
        modeCmdValid = 1'b0;
        modeCmd = '0;
        eomStart = 1'b0;
    end

    // Command word pulse, then gap cycles, then one message done pulse
    task automatic cmd(input logic tx, input logic sync, input int gap);
        modeCmdValid <= 1'b1;
        modeCmd <= '{txVector: tx, syncNoData: sync};
        @(posedge clk);
        modeCmdValid <= 1'b0;
        // Stale kind after the pulse, so the design must not use it
        modeCmd <= '{txVector: ~tx, syncNoData: ~sync};
        repeat (gap) @(posedge clk);
        eomStart <= 1'b1;
        @(posedge clk);
        eomStart <= 1'b0;
    endtask
endmodule // rmcq_bc_model

// *** rt_mode_code_irq_queue_ctl_bench.sv ***
// Self-checking bench for the mode-command and interrupt queue block.
// Assumes a zero-wait AHB-Lite slave and the bus controller model beside it.
`timescale 1ns/100ps
module rt_mode_code_irq_queue_ctl_bench;
    import rmcq_pkg::*;
    typedef struct packed {logic [15:0] cfg; logic rt, tx, sync, srq, clr;} rmcq_row_t;
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, rtMode = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = '0;
    logic modeCmdValid, eomStart, timeTagTick = 0, addrPar = 0, memPar = 0, irq, srqBit;
    logic [15:0] timeTag, tt = '0, qEv = '0;
    rmcq_mode_cmd_t modeCmd;
    rmcq_queue_wr_t queueWr;
    int errCount = 0, nCompared = 0, qCount = 0, cyc = 0;
    rmcq_row_t rows[6] = '{
        '{16'h0004, 1, 1, 0, 0, 0}, '{16'h0040, 1, 0, 1, 1, 1}, '{16'h0000, 1, 1, 1, 1, 0},
        '{16'h0044, 0, 1, 1, 1, 0}, '{16'h0044, 1, 1, 1, 0, 1}, '{16'h0040, 1, 1, 0, 1, 0}};

    rt_mode_code_irq_queue_ctl rt_mode_code_irq_queue_ctl_i (.clk(clk), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .rtMode(rtMode), .modeCmdValid(modeCmdValid), .modeCmd(modeCmd),
        .eomStart(eomStart), .timeTagTick(timeTagTick), .terminalAddrParityIrq(addrPar),
        .memParityIrq(memPar), .irq(irq), .srqBit(srqBit), .timeTag(timeTag),
        .queueWr(queueWr));
    rmcq_bc_model rmcq_bc_model_i (.clk(clk), .modeCmdValid(modeCmdValid),
        .modeCmd(modeCmd), .eomStart(eomStart));

    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (queueWr.valid === 1'b1) begin
            qCount++;
            qEv <= queueWr.events;
        end
        // Wrap run alone needs about 65,600 cycles
        if (cyc == 80000) begin
            errCount++;
            finalReport();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic pulse(input logic a, input logic m);
        addrPar <= a;
        memPar <= m;
        @(posedge clk);
        addrPar <= 1'b0;
        memPar <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic finalReport();
        $display("compared=%0d errors=%0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(32'({srqBit, irq, timeTag}), 32'h0);
        chk(32'({queueWr.valid, queueWr.events}), 32'h0);
        chk(32'(queueWr.timeTag), 32'h0);
        chk(32'(hresp), 32'(HRESP_OKAY));
        foreach (rows[i]) begin
            bus(1, CFG2_OFS, {16'h0, rows[i].cfg});
            bus(1, SRQ_OFS, 32'h1);
            timeTagTick <= 1'b1;
            rtMode <= rows[i].rt;
            @(posedge clk);
            timeTagTick <= 1'b0;
            tt = rows[i].clr ? 16'h0 : tt + 16'h1;
            rmcq_bc_model_i.cmd(rows[i].tx, rows[i].sync, 2);
            @(posedge clk);
            chk(32'(srqBit), 32'(rows[i].srq));
            bus(0, TTAG_OFS, 32'h0);
            chk(rd, {16'h0, tt});
        end
        // Queue write just before message done must not block either clear
        bus(1, CFG2_OFS, 32'h44);
        bus(1, CFG6_OFS, 32'h40);
        bus(1, IMR1_OFS, 32'h4080);
        bus(1, SRQ_OFS, 32'h1);
        fork
            rmcq_bc_model_i.cmd(1'b1, 1'b1, 6);
            begin
                repeat (5) @(posedge clk);
                addrPar <= 1'b1;
                @(posedge clk);
                addrPar <= 1'b0;
            end
        join
        @(posedge clk);
        chk(32'({srqBit, timeTag}), 32'h0);
        chk(qCount, 1);
        bus(0, ISR1_OFS, 32'h0);
        chk(rd, 32'h0080);
        pulse(1'b1, 1'b1);
        chk(qCount, 2);
        chk(32'(qEv), 32'h4080);
        chk(32'(irq), 32'h1);
        bus(0, ISR1_OFS, 32'h0);
        chk(rd, 32'h4080);
        bus(0, ISR1_OFS, 32'h0);
        chk({rd[31:1], irq}, 32'h0);
        bus(1, IMR1_OFS, 32'h0);
        pulse(1'b1, 1'b1);
        bus(0, ISR1_OFS, 32'h0);
        chk({rd[31:1], irq}, 32'h0);
        bus(1, IMR1_OFS, 32'h4000);
        bus(1, CFG6_OFS, 32'h0);
        pulse(1'b0, 1'b1);
        chk(qCount, 2);
        chk(32'(irq), 32'h1);
        bus(0, ISR1_OFS, 32'h0);
        chk(rd, 32'h4000);
        // Extended mode with wrap masked out: software polls it
        bus(1, CFG2_OFS, 32'h8000);
        bus(1, CFG6_OFS, 32'h40);
        bus(1, IMR1_OFS, 32'h0);
        pulse(1'b1, 1'b0);
        timeTagTick <= 1'b1;
        repeat (32'h10000 - {16'h0, timeTag}) @(posedge clk);
        timeTagTick <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        chk(qCount, 2);
        bus(0, ISR1_OFS, 32'h0);
        chk(rd, 32'h00c0);
        bus(0, IMR1_OFS, 32'h0);
        chk(rd, 32'h0);
        bus(0, 8'h40, 32'h0);
        chk(rd, RD_ZERO);
        // Reset in mid-run drops pending status, service request and interrupt
        bus(1, SRQ_OFS, 32'h1);
        bus(1, IMR1_OFS, 32'h4000);
        pulse(1'b0, 1'b1);
        chk(32'({srqBit, irq}), 32'h3);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(32'({srqBit, irq, timeTag}), 32'h0);
        chk(32'({queueWr.valid, queueWr.events}), 32'h0);
        bus(0, ISR1_OFS, 32'h0);
        chk(rd, 32'(ISR1_RST));
        bus(0, CFG2_OFS, 32'h0);
        chk(rd, 32'(CFG2_RST));
        finalReport();
    end
endmodule // rt_mode_code_irq_queue_ctl_bench
